// *** hw/usb3_split_link_timeout_reset.sv ***
// split-port link watchdog for downstream ports five and six
// assumes register strobes are synchronous single-cycle pulses on clk
// and link state codes come already synchronised to clk
//
// Overview of operation
// - invalid link for whole timeout on split port pulses its split power output
// - timeout counter clears and restarts on every expiry, so pulses repeat
// - timeout code zero disables the watchdog, no new pulse starts; a pulse already under way completes
// - one shared three-bit timeout code; 101b one second, 110b two seconds
// - eight-bit duration field sets how long the output stays off
// - off time is 350 ms plus 10 ms per count
// - off counter clears whenever a pulse completes
// - duration applies only to the split superspeed output, watchdog pulses
// - link invalid while state stays in codes 0x4 through 0x9
// - during a pulse output is low for the duration, then returns high
// - only ports five and six split, each watched independently
`timescale 1ns/1ps
`default_nettype none
module usb3_split_link_timeout_reset
  import split_link_wd_pkg::*;
#(
  parameter longint MS_CYCLES = CYCLES_PER_MS,
  parameter int     NPORTS    = 2
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register port
  input  wire reg_req_t          reg_req,
  output logic [7:0]             reg_rdata,
  // ports five (index 0) and six (index 1)
  input  wire port_in_t          port_in [NPORTS],
  output logic [NPORTS-1:0]      superspeed_split_power_out
);

  if (NPORTS != 2 || MS_CYCLES < 1) begin : g_bad_param
    $error("watchdog serves exactly two ports and a positive ms tick");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0] sel_q, sel_d;
  logic [7:0] dur_q, dur_d;
  logic [7:0] rdata_d;

  always_comb begin
    sel_d   = sel_q;
    dur_d   = dur_q;
    rdata_d = reg_rdata;
    if (reg_req.wr && reg_req.addr == TIMEOUT_SELECT_ADDR)
      sel_d = reg_req.wdata[SELECT_MSB:0];
    if (reg_req.wr && reg_req.addr == OFF_DURATION_ADDR)
      dur_d = reg_req.wdata;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        TIMEOUT_SELECT_ADDR: rdata_d = {5'h00, sel_q};
        OFF_DURATION_ADDR:   rdata_d = dur_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q     <= TIMEOUT_SELECT_RST[2:0];
      dur_q     <= OFF_DURATION_RST;
      reg_rdata <= 8'h00;
    end else begin
      sel_q     <= sel_d;
      dur_q     <= dur_d;
      reg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // shared millisecond tick
  // ----------------------------------------------------------------
  // one prescaler keeps per-port counters small; timing granularity is 1 ms
  localparam int PW = $clog2(MS_CYCLES + 1);
  logic [PW-1:0] pre_q, pre_d;
  logic          tick;

  assign tick = (pre_q == PW'(MS_CYCLES - 1));

  always_comb begin
    pre_d = tick ? '0 : pre_q + PW'(1);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) pre_q <= '0;
    else     pre_q <= pre_d;
  end

  function automatic logic [11:0] timeout_ms(input logic [2:0] code);
    unique case (code)
      3'b001:  timeout_ms = 12'(TO_100_MS);
      3'b010:  timeout_ms = 12'(TO_250_MS);
      3'b011:  timeout_ms = 12'(TO_500_MS);
      3'b100:  timeout_ms = 12'(TO_750_MS);
      3'b101:  timeout_ms = 12'(TO_1000_MS);
      3'b110:  timeout_ms = 12'(TO_2000_MS);
      default: timeout_ms = 12'h000;
    endcase
  endfunction

  function automatic logic link_invalid(input logic [3:0] st);
    link_invalid = (st >= LINK_INVALID_LO) && (st <= LINK_INVALID_HI);
  endfunction

  logic [11:0] limit_ms;
  logic [11:0] off_ms;
  assign limit_ms = timeout_ms(sel_q);
  assign off_ms   = 12'(OFF_BASE_MS) + 12'(OFF_STEP_MS) * {4'h0, dur_q};

  // ----------------------------------------------------------------
  // per-port watchdog
  // ----------------------------------------------------------------
  wd_state_t   st_q  [NPORTS];
  wd_state_t   st_d  [NPORTS];
  logic [11:0] cnt_q [NPORTS];
  logic [11:0] cnt_d [NPORTS];
  logic [NPORTS-1:0] pwr_d;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    always_comb begin
      st_d[p]  = st_q[p];
      cnt_d[p] = cnt_q[p];
      pwr_d[p] = superspeed_split_power_out[p];
      unique case (st_q[p])
        ST_IDLE: begin
          cnt_d[p] = '0;
          pwr_d[p] = 1'b1;
          if (port_in[p].split_en && limit_ms != 12'h000)
            st_d[p] = ST_WATCH;
        end
        ST_WATCH: begin
          if (!port_in[p].split_en || limit_ms == 12'h000) begin
            st_d[p]  = ST_IDLE;
            cnt_d[p] = '0;
          end else if (!link_invalid(port_in[p].link_state_status)) begin
            cnt_d[p] = '0;
          end else if (tick) begin
            if (cnt_q[p] + 12'h001 >= limit_ms) begin
              cnt_d[p] = '0;
              st_d[p]  = ST_OFF;
              pwr_d[p] = 1'b0;
            end else begin
              cnt_d[p] = cnt_q[p] + 12'h001;
            end
          end
        end
        ST_OFF: begin
          // only watchdog pulses use the off duration
          if (tick) begin
            if (cnt_q[p] + 12'h001 >= off_ms) begin
              cnt_d[p] = '0;
              st_d[p]  = ST_WATCH;
              pwr_d[p] = 1'b1;
            end else begin
              cnt_d[p] = cnt_q[p] + 12'h001;
            end
          end
        end
        default: begin
          st_d[p]  = ST_IDLE;
          cnt_d[p] = '0;
          pwr_d[p] = 1'b1;
        end
      endcase
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        st_q[p]  <= ST_IDLE;
        cnt_q[p] <= '0;
        superspeed_split_power_out[p] <= 1'b1;
      end else begin
        st_q[p]  <= st_d[p];
        cnt_q[p] <= cnt_d[p];
        superspeed_split_power_out[p] <= pwr_d[p];
      end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // a pulse already under way still completes after disabling
    property p_disabled_high;
      @(posedge clk) disable iff (rst)
        (limit_ms == 12'h000 && st_q[p] != ST_OFF) |=> superspeed_split_power_out[p];
    endproperty
    a_disabled_high: assert property (p_disabled_high)
      else $error("split power dropped while watchdog disabled");

    property p_low_in_off;
      @(posedge clk) disable iff (rst)
        (st_q[p] == ST_OFF) |-> !superspeed_split_power_out[p];
    endproperty
    a_low_in_off: assert property (p_low_in_off)
      else $error("split power high during recovery pulse");

    property p_fall_from_expiry;
      @(posedge clk) disable iff (rst)
        $fell(superspeed_split_power_out[p]) |->
          $past(st_q[p] == ST_WATCH) && $past(cnt_q[p]) + 12'h001 >= $past(limit_ms);
    endproperty
    a_fall_from_expiry: assert property (p_fall_from_expiry)
      else $error("split power fell without an expired timeout");

    property p_restart;
      @(posedge clk) disable iff (rst)
        $fell(superspeed_split_power_out[p]) |-> cnt_q[p] == 12'h000;
    endproperty
    a_restart: assert property (p_restart)
      else $error("timeout counter not cleared at expiry");

    property p_off_clear;
      @(posedge clk) disable iff (rst)
        ($past(st_q[p]) == ST_OFF && st_q[p] == ST_WATCH) |->
          cnt_q[p] == 12'h000 && superspeed_split_power_out[p];
    endproperty
    a_off_clear: assert property (p_off_clear)
      else $error("off counter not cleared when pulse ended");

    property p_off_length;
      @(posedge clk) disable iff (rst)
        (st_q[p] == ST_OFF) |-> cnt_q[p] < off_ms;
    endproperty
    a_off_length: assert property (p_off_length)
      else $error("off counter passed programmed duration");

    property p_valid_clears;
      @(posedge clk) disable iff (rst)
        (st_q[p] == ST_WATCH && !link_invalid(port_in[p].link_state_status)) |=>
          cnt_q[p] == 12'h000;
    endproperty
    a_valid_clears: assert property (p_valid_clears)
      else $error("valid link state did not clear timeout counter");

    property p_no_split_idle;
      @(posedge clk) disable iff (rst)
        (!port_in[p].split_en && st_q[p] == ST_WATCH) |=> st_q[p] == ST_IDLE;
    endproperty
    a_no_split_idle: assert property (p_no_split_idle)
      else $error("port watched with splitting off");

    c_pulse: cover property (@(posedge clk) disable iff (rst)
      $fell(superspeed_split_power_out[p]));
    c_pulse_end: cover property (@(posedge clk) disable iff (rst)
      $rose(superspeed_split_power_out[p]));
    c_valid_rescue: cover property (@(posedge clk) disable iff (rst)
      st_q[p] == ST_WATCH && cnt_q[p] != 12'h000 ##1 cnt_q[p] == 12'h000);
  end

  property p_sel_mask;
    @(posedge clk) disable iff (rst)
      reg_req.rd && reg_req.addr == TIMEOUT_SELECT_ADDR |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_sel_mask: assert property (p_sel_mask)
    else $error("reserved timeout bits read nonzero");

endmodule
`default_nettype wire

// *** hw/split_link_wd_pkg.sv ***
// package for the split-port link watchdog: register map, timing constants, carriers
// assumes a 200 MHz core clock
package split_link_wd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] TIMEOUT_SELECT_ADDR = 16'h4171;
  localparam logic [15:0] OFF_DURATION_ADDR   = 16'h4176;
  localparam logic [7:0]  TIMEOUT_SELECT_RST  = 8'h05;
  localparam logic [7:0]  OFF_DURATION_RST    = 8'h05;
  localparam int          SELECT_MSB          = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ         = 200000000;
  localparam longint CYCLES_PER_MS  = CLK_HZ / 1000;
  localparam longint OFF_BASE_MS    = 350;
  localparam longint OFF_STEP_MS    = 10;
  localparam longint TO_100_MS      = 100;
  localparam longint TO_250_MS      = 250;
  localparam longint TO_500_MS      = 500;
  localparam longint TO_750_MS      = 750;
  localparam longint TO_1000_MS     = 1000;
  localparam longint TO_2000_MS     = 2000;

  // link states that count as not yet valid
  localparam logic [3:0] LINK_INVALID_LO = 4'h4;
  localparam logic [3:0] LINK_INVALID_HI = 4'h9;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic        split_en;
    logic [3:0]  link_state_status;
  } port_in_t;

  typedef enum logic [2:0] {
    ST_WATCH = 3'b001,
    ST_OFF   = 3'b010,
    ST_IDLE  = 3'b100
  } wd_state_t;

endpackage

// *** tb/emb_ss_dev.sv ***
// model of an embedded superspeed device behind one split power switch
// assumes the power line is high while the switch is on
`timescale 1ns/1ps
`default_nettype none
module emb_ss_dev (
  // power and fault control
  input  wire logic       pwr,
  input  wire logic       stuck,
  // link state seen by the hub
  output logic [3:0]      link_state_status
);
  // unpowered or faulty device parks in receiver detect, else link is up
  assign link_state_status = (!pwr || stuck) ? 4'h5 : 4'h0;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the split-port link watchdog
// assumes one 200 MHz clock and a shortened millisecond prescaler
`timescale 1ns/1ps
`default_nettype none
module tb;
  import split_link_wd_pkg::*;
  localparam int MSC = 4;
  logic        clk;
  logic        rst;
  reg_req_t    req;
  logic [7:0]  rdata;
  port_in_t    pin [2];
  logic [3:0]  lss [2];
  logic [1:0]  out;
  logic [1:0]  en;
  logic [1:0]  stuck;
  int          failures;
  int          n_compared;
  int          to_ms [7] = '{0, 100, 250, 500, 750, 1000, 2000};

  // ----------------------------------------------------------------
  // design and embedded devices
  // ----------------------------------------------------------------
  usb3_split_link_timeout_reset #(.MS_CYCLES(MSC), .NPORTS(2)) u_usb3_split_link_timeout_reset (
    .clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
    .port_in(pin), .superspeed_split_power_out(out));
  for (genvar i = 0; i < 2; i++) begin : g_dev
    emb_ss_dev u_emb_ss_dev (.pwr(out[i]), .stuck(stuck[i]), .link_state_status(lss[i]));
    always_comb pin[i] = '{split_en: en[i], link_state_status: lss[i]};
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) req <= '0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) req <= '0;
    @(negedge clk) d = rdata;
  endtask

  // bounded wait on one power output, counts negedges
  task automatic wait_out(input int p, input logic v, input int lim, output int n);
    n = 0;
    while (out[p] !== v) begin
      @(negedge clk) n++;
      if (n > lim) begin
        failures++;
        $display("wrong value at %0t: output wait ran out", $time);
        end_sim;
      end
    end
  endtask

  task automatic regs;
    logic [7:0] v;
    rd(TIMEOUT_SELECT_ADDR, v);
    chk(v, TIMEOUT_SELECT_RST, "select reset");
    rd(OFF_DURATION_ADDR, v);
    chk(v, OFF_DURATION_RST, "duration reset");
    wr(TIMEOUT_SELECT_ADDR, 8'hFF);
    rd(TIMEOUT_SELECT_ADDR, v);
    chk(v, 8'h07, "select upper bits");
    wr(OFF_DURATION_ADDR, 8'hA5);
    rd(OFF_DURATION_ADDR, v);
    chk(v, 8'hA5, "duration");
    rd(16'h4172, v);
    chk(v, 8'h00, "unmapped read");
  endtask

  // stuck link on port p: fall time, off time, optional repeat
  task automatic pulse(input int p, input int c, input int d, input bit twice);
    int n, t, w;
    wr(TIMEOUT_SELECT_ADDR, 8'(c));
    wr(OFF_DURATION_ADDR, 8'(d));
    t = to_ms[c] * MSC;
    w = (350 + 10 * d) * MSC;
    @(posedge clk) en <= 2'(1 << p);
    stuck <= 2'(1 << p);
    repeat (twice ? 2 : 1) begin
      wait_out(p, 1'b0, t + 20, n);
      chk(n >= t - 4 && n <= t + 8, 1, "time to pulse");
      chk(out[1 - p], 1'b1, "other port power");
      wait_out(p, 1'b1, w + 20, n);
      chk(n >= w - 1 && n <= w + 1, 1, "off time");
    end
    @(posedge clk) stuck <= 2'b00;
    en <= 2'b00;
    wait_out(p, 1'b1, w + 20, n);
  endtask

  // watchdog must stay silent although both links are stuck
  task automatic quiet(input logic [2:0] c, input logic [1:0] e);
    int lows;
    lows = 0;
    wr(TIMEOUT_SELECT_ADDR, {5'h00, c});
    @(posedge clk) en <= e;
    stuck <= 2'b11;
    // longer than the longest selectable timeout
    repeat (to_ms[6] * MSC + 100) begin
      @(negedge clk) lows += (out !== 2'b11);
    end
    chk(lows, 0, "silent watchdog");
    @(posedge clk) stuck <= 2'b00;
    en <= 2'b00;
  endtask

  // link comes up briefly before expiry, so counting must start over
  task automatic rescue;
    int n;
    wr(TIMEOUT_SELECT_ADDR, 8'h01);
    @(posedge clk) en <= 2'b10;
    stuck <= 2'b10;
    repeat (300) @(posedge clk);
    stuck <= 2'b00;
    repeat (20) @(posedge clk);
    stuck <= 2'b10;
    wait_out(1, 1'b0, 600, n);
    chk(n >= 396 && n <= 408, 1, "restart after valid link");
    chk(out[0], 1'b1, "other port power");
    wait_out(1, 1'b1, 4000, n);
    @(posedge clk) stuck <= 2'b00;
    en <= 2'b00;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    n_compared = 0;
    rst = 1'b1;
    req = '0;
    en = 2'b00;
    stuck = 2'b00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    regs;
    pulse(0, 1, 0, 1'b1);
    pulse(1, 2, 255, 1'b0);
    for (int c = 3; c <= 6; c++) pulse(0, c, c, 1'b0);
    rescue;
    quiet(3'd0, 2'b11);
    quiet(3'd7, 2'b11);
    quiet(3'd1, 2'b00);
    end_sim;
  end
endmodule
`default_nettype wire
